// *** core/hsu_pkg.sv ***
// Package with the register map, field positions and timing of the sync gate and break timer
package hsu_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL    = 5'h00;
   localparam logic [4:0] OFS_STATUS  = 5'h04;
   localparam logic [4:0] OFS_MASK    = 5'h08;
   localparam logic [4:0] OFS_BRK_TMR = 5'h0C;
   localparam logic [4:0] OFS_SYN_TMR = 5'h10;
   localparam logic [4:0] OFS_SYN_CMP = 5'h14;

   // Fields of sync_control_0
   localparam int CTRL_SYNC_EN = 2;
   localparam int CTRL_CMP_EN  = 5;
   localparam int CTRL_MODE    = 6;
   localparam int CTRL_GATE    = 8;

   // Fields of sync_status and of the mask register
   localparam int ST_BRK_COND = 0;
   localparam int ST_BT_CMP   = 1;
   localparam int ST_BT_OVF   = 2;
   localparam int ST_SYN_CMP  = 3;
   localparam int ST_SYNC_DET = 4;
   localparam int ST_W        = 5;

   // Reset values
   localparam logic [ST_W-1:0] STATUS_RST  = 5'h00;
   localparam logic [ST_W-1:0] MASK_RST    = 5'h00;
   localparam logic [15:0]     TMR_RST     = 16'h0000;
   localparam logic [15:0]     BT_CMP_RST  = 16'hFFFF;
   localparam logic [15:0]     ST_CMP_RST  = 16'hFFFF;
   localparam logic [15:0]     TMR_MAX     = 16'hFFFF;
   localparam logic [2:0]      SYNC_FALLS  = 3'h5;

   // Timing: shortest break is eleven bit times at 19200 baud
   localparam int CLK_MHZ        = 40;
   localparam int LIN_BIT_NS     = 52083;
   localparam int BREAK_BITS     = 11;
   localparam int BREAK_MIN_NS   = BREAK_BITS * LIN_BIT_NS;
   localparam int BREAK_MIN_CYC  = (BREAK_MIN_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      LS_IDLE,
      LS_SYNC,
      LS_DONE
   } hsu_lin_t;

endpackage

// *** core/hsu_sync2.sv ***
// Two-stage synchroniser for one asynchronous input level
module hsu_sync2 (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;

   // Idles high like the bus so no edge is seen out of reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         dout   <= 1'b1;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// *** core/hsu_top.sv ***
// Receive gate, break timer, sync timer and Avalon-MM register file of the sync unit
// How it works
// - LIN mode, gate 1: UART receive held high until break and sync found.
// - LIN mode, gate 0: bus data reaches the UART receive input.
// - Pulse-width read mode, gate 1: each rising edge sets status bit 0.
// - Pulse-width read mode: break timer runs from falling to next rising edge.
// - Break timer compare match and overflow always raise their own flags.
// - Pulse-width write mode, gate 0: no break-condition flag on rising edges.
// - Pulse-width write mode: sync timer compare sets status bit 3.
// - Pulse-width write mode: break timer also stops on a rising edge.
// - Control bit 6 selects LIN when 0, pulse-width bus when 1.
// - Compare enabled: sync timer equal to compare sets flag, and interrupt when mask bit 3 is set.
module hsu_top
   import hsu_pkg::*;
#(
   parameter logic [15:0] BREAK_MIN = 16'(BREAK_MIN_CYC)
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   input  wire logic        bus_rx_pin,
   output logic             uart_rxd
);

   typedef struct packed {
      logic            rx_prev;
      hsu_lin_t        lin;
      logic [2:0]      fall_cnt;
      logic            mode;
      logic            gate;
      logic            cmp_en;
      logic            sync_en;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic            bt_run;
      logic [15:0]     bt_cnt;
      logic [15:0]     bt_cmp;
      logic [15:0]     st_cnt;
      logic [15:0]     st_cmp;
      logic            ack;
      logic [31:0]     rdata;
      logic            rxd;
   } hsu_state_t;

   hsu_state_t s_q;
   hsu_state_t s_d;

   logic            rx_s;
   logic            fall;
   logic            rise;
   logic            bt_inc;
   logic            st_inc;
   logic            brk_ev;
   logic            req;
   logic            wr_hit;
   logic [ST_W-1:0] set_v;
   logic [ST_W-1:0] clr_v;
   logic [15:0]     bt_next;
   logic [15:0]     st_next;

   hsu_sync2 u_rx_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .din     (bus_rx_pin),
      .dout    (rx_s)
   );

   assign fall    = s_q.rx_prev & ~rx_s;
   assign rise    = ~s_q.rx_prev & rx_s;
   assign req     = avs_read | avs_write;
   assign wr_hit  = avs_write & s_q.ack;
   assign bt_inc  = s_q.bt_run & ~fall & ~rise & (s_q.bt_cnt != TMR_MAX);
   assign st_inc  = s_q.sync_en & ~fall & (s_q.st_cnt != TMR_MAX);
   assign bt_next = s_q.bt_cnt + 16'h0001;
   assign st_next = s_q.st_cnt + 16'h0001;
   // Break seen once a low pulse reaches the shortest break width
   assign brk_ev  = ~s_q.mode & s_q.sync_en & bt_inc & (bt_next == BREAK_MIN);

   always_comb begin
      s_d         = s_q;
      set_v       = '0;
      clr_v       = '0;
      s_d.rx_prev = rx_s;

      // Break timer measures each low pulse in either mode
      if (fall) begin
         s_d.bt_run = 1'b1;
         s_d.bt_cnt = TMR_RST;
      end else if (rise) begin
         s_d.bt_run = 1'b0;
      end else if (bt_inc) begin
         s_d.bt_cnt = bt_next;
      end
      set_v[ST_BT_CMP] = bt_inc & (bt_next == s_q.bt_cmp);
      set_v[ST_BT_OVF] = bt_inc & (bt_next == TMR_MAX);

      // Rising edge flag only in pulse-width read mode
      set_v[ST_BRK_COND] = s_q.mode & s_q.gate & rise;

      // Sync bit timer restarts on each falling edge
      if (!s_q.sync_en || fall) begin
         s_d.st_cnt = TMR_RST;
      end else if (st_inc) begin
         s_d.st_cnt = st_next;
      end
      set_v[ST_SYN_CMP] = s_q.cmp_en & st_inc & (st_next == s_q.st_cmp);

      // LIN break then sync byte: five falling edges, then the stop bit rises
      if (s_q.mode || !s_q.sync_en) begin
         s_d.lin = LS_IDLE;
      end else if (brk_ev) begin
         s_d.lin      = LS_SYNC;
         s_d.fall_cnt = 3'h0;
      end else begin
         unique case (s_q.lin)
            LS_IDLE: begin
               s_d.fall_cnt = 3'h0;
            end
            LS_SYNC: begin
               if (fall) begin
                  s_d.fall_cnt = s_q.fall_cnt + 3'h1;
               end else if (rise && s_q.fall_cnt == SYNC_FALLS) begin
                  s_d.lin = LS_DONE;
                  set_v[ST_SYNC_DET] = 1'b1;
               end
            end
            LS_DONE: begin
               s_d.fall_cnt = 3'h0;
            end
         endcase
      end

      // Gate holds the UART input idle until a full break and sync are seen
      if (!s_q.mode && s_q.gate && s_q.lin != LS_DONE) begin
         s_d.rxd = 1'b1;
      end else begin
         s_d.rxd = rx_s;
      end

      // Bus slave: one wait state, read data captured with the answer
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack) begin
         unique case (avs_address)
            OFS_CTRL: begin
               s_d.rdata = '0;
               s_d.rdata[CTRL_SYNC_EN] = s_q.sync_en;
               s_d.rdata[CTRL_CMP_EN]  = s_q.cmp_en;
               s_d.rdata[CTRL_MODE]    = s_q.mode;
               s_d.rdata[CTRL_GATE]    = s_q.gate;
            end
            OFS_STATUS:  s_d.rdata = {27'h0, s_q.status};
            OFS_MASK:    s_d.rdata = {27'h0, s_q.mask};
            OFS_BRK_TMR: s_d.rdata = {16'h0, s_q.bt_cnt};
            OFS_SYN_TMR: s_d.rdata = {16'h0, s_q.st_cnt};
            OFS_SYN_CMP: s_d.rdata = {16'h0, s_q.st_cmp};
            default:     s_d.rdata = 32'h0000_0000;
         endcase
      end

      if (wr_hit) begin
         unique case (avs_address)
            OFS_CTRL: begin
               s_d.sync_en = avs_writedata[CTRL_SYNC_EN];
               s_d.cmp_en  = avs_writedata[CTRL_CMP_EN];
               s_d.mode    = avs_writedata[CTRL_MODE];
               s_d.gate    = avs_writedata[CTRL_GATE];
            end
            OFS_STATUS:  clr_v      = avs_writedata[ST_W-1:0];
            OFS_MASK:    s_d.mask   = avs_writedata[ST_W-1:0];
            OFS_BRK_TMR: s_d.bt_cmp = avs_writedata[15:0];
            OFS_SYN_TMR: s_d.st_cnt = TMR_RST;
            OFS_SYN_CMP: s_d.st_cmp = avs_writedata[15:0];
            default: begin
            end
         endcase
      end

      // A new event beats a clear in the same cycle so no event is lost
      s_d.status = (s_q.status & ~clr_v) | set_v;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.rx_prev  <= 1'b1;
         s_q.lin      <= LS_IDLE;
         s_q.fall_cnt <= 3'h0;
         s_q.mode     <= 1'b0;
         s_q.gate     <= 1'b0;
         s_q.cmp_en   <= 1'b0;
         s_q.sync_en  <= 1'b0;
         s_q.status   <= STATUS_RST;
         s_q.mask     <= MASK_RST;
         s_q.bt_run   <= 1'b0;
         s_q.bt_cnt   <= TMR_RST;
         s_q.bt_cmp   <= BT_CMP_RST;
         s_q.st_cnt   <= TMR_RST;
         s_q.st_cmp   <= ST_CMP_RST;
         s_q.ack      <= 1'b0;
         s_q.rdata    <= 32'h0000_0000;
         s_q.rxd      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_waitrequest = req & ~s_q.ack;
   assign avs_readdata    = s_q.rdata;
   assign uart_rxd        = s_q.rxd;
   assign irq             = |(s_q.status & s_q.mask);

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_low_start;
      fall ##1 s_q.bt_run;
   endsequence

   sequence seq_rise_stop;
      rise ##1 !s_q.bt_run;
   endsequence

   a_gate_holds_rxd: assert property (
      !s_q.mode && s_q.gate && s_q.lin != LS_DONE |=> uart_rxd)
      else $error("UART input not held high while gated");

   a_open_passes_rxd: assert property (
      !s_q.mode && !s_q.gate |=> uart_rxd == $past(rx_s))
      else $error("UART input does not follow bus with gate open");

   a_rise_sets_brk: assert property (
      s_q.mode && s_q.gate && rise |=> s_q.status[ST_BRK_COND])
      else $error("Rising edge did not set break condition");

   a_timer_window: assert property (
      seq_low_start |-> s_q.bt_cnt == TMR_RST)
      else $error("Break timer did not start on falling edge");

   a_timer_stop_rise: assert property (
      seq_rise_stop |-> $stable(s_q.bt_cnt) || fall)
      else $error("Break timer kept counting after rising edge");

   a_bt_cmp_flag: assert property (
      bt_inc && bt_next == s_q.bt_cmp |=> s_q.status[ST_BT_CMP] && s_q.bt_cnt == s_q.bt_cmp)
      else $error("Break timer compare flag missed");

   a_bt_ovf_flag: assert property (
      s_q.bt_run && s_q.bt_cnt == TMR_MAX && $changed(s_q.bt_cnt) |-> s_q.status[ST_BT_OVF])
      else $error("Break timer overflow flag missed");

   a_no_brk_write: assert property (
      s_q.mode && !s_q.gate && !s_q.status[ST_BRK_COND] && !wr_hit
      |=> !s_q.status[ST_BRK_COND])
      else $error("Break condition flag set in write mode");

   a_syn_cmp_flag: assert property (
      s_q.cmp_en && st_inc && st_next == s_q.st_cmp
      |=> s_q.status[ST_SYN_CMP] && (irq || !s_q.mask[ST_SYN_CMP]))
      else $error("Sync compare flag missed");

   a_irq_level: assert property (
      s_q.status[ST_SYN_CMP] && s_q.mask[ST_SYN_CMP] |-> irq)
      else $error("Interrupt low with unmasked sync compare");

   a_mode_lin_only: assert property (
      s_q.mode |=> s_q.lin == LS_IDLE)
      else $error("LIN sequencer active in pulse-width mode");

   a_brk_to_sync: assert property (
      brk_ev |=> s_q.lin == LS_SYNC && s_q.fall_cnt == 3'h0)
      else $error("Break did not start sync search");

   a_sync_sets_det: assert property (
      s_q.lin == LS_SYNC && !s_q.mode && s_q.sync_en && rise && s_q.fall_cnt == SYNC_FALLS
      |=> s_q.lin == LS_DONE && s_q.status[ST_SYNC_DET])
      else $error("Sync byte end not detected");

   a_done_passes: assert property (
      !s_q.mode && s_q.lin == LS_DONE |=> uart_rxd == $past(rx_s))
      else $error("UART input not passed after sync");

   a_no_brk_lin: assert property (
      !s_q.mode && !wr_hit && !s_q.status[ST_BRK_COND] |=> !s_q.status[ST_BRK_COND])
      else $error("Break condition flag set in LIN mode");

   a_brk_irq: assert property (
      s_q.mode && s_q.gate && rise && s_q.mask[ST_BRK_COND] && !wr_hit |=> irq)
      else $error("Break condition interrupt missing");

   a_timer_counts: assert property (
      bt_inc |=> s_q.bt_cnt == $past(s_q.bt_cnt) + 16'h0001)
      else $error("Break timer did not advance");

   a_timer_idle: assert property (
      !s_q.bt_run && !fall |=> $stable(s_q.bt_cnt))
      else $error("Break timer moved while stopped");

   a_write_mode_stop: assert property (
      s_q.mode && !s_q.gate && rise |=> !s_q.bt_run)
      else $error("Break timer ran on after rising edge");

   a_timer_sat: assert property (
      s_q.bt_cnt == TMR_MAX && !fall |=> s_q.bt_cnt == TMR_MAX)
      else $error("Break timer wrapped");

   a_ovf_reach: assert property (
      bt_inc && bt_next == TMR_MAX |=> s_q.status[ST_BT_OVF] && s_q.bt_cnt == TMR_MAX)
      else $error("Overflow not flagged at full count");

   a_syn_cmp_quiet: assert property (
      !s_q.cmp_en && !s_q.status[ST_SYN_CMP] && !wr_hit |=> !s_q.status[ST_SYN_CMP])
      else $error("Sync compare flag set while disabled");

   a_syn_restart: assert property (
      s_q.sync_en && fall |=> s_q.st_cnt == TMR_RST)
      else $error("Sync timer not restarted on falling edge");

   a_sync_timer_off: assert property (
      !s_q.sync_en |=> s_q.st_cnt == TMR_RST)
      else $error("Sync timer runs while disabled");

   a_status_w1c: assert property (
      wr_hit && avs_address == OFS_STATUS && avs_writedata[ST_BRK_COND]
      && !set_v[ST_BRK_COND] |=> !s_q.status[ST_BRK_COND])
      else $error("Status bit not cleared by writing one");

   a_irq_quiet: assert property (
      (s_q.status & s_q.mask) == '0 |-> !irq)
      else $error("Interrupt high with nothing pending");

   a_read_status: assert property (
      req && !s_q.ack && avs_address == OFS_STATUS
      |=> avs_readdata == {27'h0, $past(s_q.status)})
      else $error("Status read data wrong");

   a_wait_first: assert property (
      req && !s_q.ack |-> avs_waitrequest)
      else $error("No wait state in first request cycle");

   a_bus_answer: assert property (
      req && !s_q.ack |=> !avs_waitrequest || !req)
      else $error("Bus answer later than one wait state");

endmodule

// *** tb/hsu_bus_node.sv ***
// Bus node model that drives the single-wire bus level
module hsu_bus_node (
   input  wire logic sys_clk,
   output logic      bus_rx_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pulled-up bus idles high
   initial bus_rx_pin = 1'b1;
   // Low for n clocks, then released high for n clocks but at most 64
   // Capping the idle time keeps the overflow pulse inside the run budget
   task automatic low(input int n);
      bus_rx_pin <= 1'b0;
      repeat (n) @(posedge sys_clk);
      bus_rx_pin <= 1'b1;
      repeat ((n > 64) ? 64 : n) @(posedge sys_clk);
   endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the sync gate and break timer
module tb_top import hsu_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        bus_rx_pin;
   logic        uart_rxd;
   logic [31:0] seed = 32'hCE8E9C57;
   logic [31:0] r;
   int          failures = 0;
   int          checks = 0;
   int          cyc = 0;
   int          n;
   always #12.5 sys_clk = ~sys_clk;
   // Short break length keeps the LIN test brief
   hsu_top #(.BREAK_MIN(16'h0014)) hsu_top_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .bus_rx_pin(bus_rx_pin), .uart_rxd(uart_rxd));
   hsu_bus_node hsu_bus_node_inst (.sys_clk(sys_clk), .bus_rx_pin(bus_rx_pin));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Edge detection latency blurs the count by a clock or two
   function automatic logic [31:0] in_win(input logic [31:0] g, input int w);
      return 32'((g >= 32'(w - 2)) && (g <= 32'(w + 2)));
   endfunction
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One Avalon access, request held until waitrequest is seen low
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic pulse_st(input int w, input logic [31:0] e);
      hsu_bus_node_inst.low(w);
      repeat (4) @(posedge sys_clk);
      rdc(OFS_STATUS, e);
      acc(1'b0, OFS_BRK_TMR, 32'h0);
   endtask
   task automatic rxd_at(input int w, input logic e);
      fork
         hsu_bus_node_inst.low(w);
         begin
            repeat (w / 2 + 4) @(posedge sys_clk);
            chk(32'(uart_rxd), 32'(e));
         end
      join
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 95000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_MASK, 32'h0);
      rdc(OFS_BRK_TMR, 32'h0);
      chk({30'h0, irq, uart_rxd}, 32'h1);
      wr(OFS_MASK, 32'h1F);
      wr(OFS_CTRL, 32'h140);
      for (int i = 0; i < 4; i++) begin
         n = 8 + int'(xs() % 32'd40);
         pulse_st(n, 32'h1);
         chk(in_win(r, n), 32'h1);
         chk(32'(irq), 32'h1);
         wr(OFS_STATUS, 32'h1F);
      end
      $display("test read mode done");
      wr(OFS_CTRL, 32'h40);
      n = 8 + int'(xs() % 32'd40);
      pulse_st(n, 32'h0);
      chk(in_win(r, n), 32'h1);
      n = 6 + int'(xs() % 32'd10);
      wr(OFS_BRK_TMR, 32'(n));
      pulse_st(n + 10, 32'h2);
      wr(OFS_STATUS, 32'h1F);
      wr(OFS_BRK_TMR, 32'h8000);
      pulse_st(65600, 32'h6);
      wr(OFS_STATUS, 32'h1F);
      $display("test write mode done");
      wr(OFS_SYN_CMP, 32'h1E);
      wr(OFS_CTRL, 32'h44);
      wr(OFS_SYN_TMR, 32'h0);
      repeat (40) @(posedge sys_clk);
      rdc(OFS_STATUS, 32'h0);
      wr(OFS_CTRL, 32'h64);
      wr(OFS_SYN_TMR, 32'h0);
      repeat (40) @(posedge sys_clk);
      rdc(OFS_STATUS, 32'h8);
      chk(32'(irq), 32'h1);
      wr(OFS_STATUS, 32'h1F);
      $display("test sync compare done");
      wr(OFS_CTRL, 32'h104);
      rxd_at(30, 1'b1);
      repeat (4) hsu_bus_node_inst.low(3);
      rxd_at(3, 1'b1);
      rdc(OFS_STATUS, 32'h10);
      rxd_at(12, 1'b0);
      wr(OFS_CTRL, 32'h004);
      rxd_at(12, 1'b0);
      $display("test lin gate done");
      wrap_up();
   end
endmodule
